// ==== hdl/adcgc_global_config.sv ====
// global configuration registers, register command decoder and conversion pacing
// Notes on behaviour
// - config_a bit 7 picks conversion mode: 0 continuous (default), 1 single-shot.
// - three-bit rate_select sets shared ratio 1024 down to 16; default 010; 111 forbidden.
// - config_b bit 6 enables lead comparators; cleared by default.
// - config_b bit 5 powers the reference buffer; cleared keeps it down.
// - config_b bit 4 selects higher reference level; low level by default.
// - config_b bit 3 drives oscillator clock to pin when internal oscillator used.
// - config_b bit 1 turns the internal test signal on; off by default.
// - config_b bit 0 makes the test signal a 1 Hz square wave, else dc.
`timescale 1ns/1ps
`include "adcgc_defines.svh"
`default_nettype none
module adcgc_global_config #(
   parameter int MOD_DIV = 4,
   parameter int TEST_HALF_CYCLES = `ADCGC_TEST_HALF_CYCLES
) (
   input wire logic clk,
   input wire logic rstn,
   input wire logic frame_active,
   input wire logic [7:0] cmd_byte,
   input wire logic cmd_byte_valid,
   input wire logic start_pin,
   input wire logic internal_osc_pin,
   output logic [7:0] read_byte,
   output logic read_byte_valid,
   output logic lead_comparator_on,
   output logic refbuffer_on,
   output logic high_reference_select,
   output logic osc_clock_out_enable,
   output logic test_signal_on,
   output logic test_signal_level,
   output logic [7:0] lead_detect_control,
   output logic single_shot_mode,
   output logic [2:0] rate_select,
   output logic converting,
   output logic data_ready
);
   logic [7:0] config_a_q;
   logic [7:0] config_b_q;
   logic [7:0] lead_ctrl_q;
   adcgc_pkg::adcgc_cmd_state_type state_q;
   logic [4:0] addr_q;
   logic [4:0] count_q;
   logic [7:0] rd_q;
   logic rd_valid_q;
   logic wr_now;
   logic [7:0] reg_view;
   logic [2:0] start_sync_q;
   logic [2:0] osc_sync_q;
   logic start_level_q;
   logic osc_level_q;
   logic start_rise;
   logic [15:0] mod_cnt_q;
   logic mod_tick;
   logic [10:0] osr;
   logic [10:0] dec_cnt_q;
   logic run_q;
   logic ready_q;
   logic [31:0] test_cnt_q;
   logic test_phase_q;
   logic test_level_q;
   logic [7:0] out_cfg_q;
   logic clk_out_q;
   logic op_write_q;

   // register contents seen by a read; unmapped addresses read zero
   always_comb begin
      case (addr_q)
         `ADCGC_ADDR_CONFIG_A: reg_view = config_a_q;
         `ADCGC_ADDR_CONFIG_B: reg_view = config_b_q;
         `ADCGC_ADDR_LEAD_CTRL: reg_view = lead_ctrl_q;
         default: reg_view = 8'h00;
      endcase
   end

   assign wr_now = cmd_byte_valid && frame_active && (state_q == adcgc_pkg::ADCGC_WRITE);

   // command decoder; dropping the frame abandons any command half done
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         state_q <= adcgc_pkg::ADCGC_IDLE;
         addr_q <= 5'h00;
         count_q <= 5'h00;
      end else if (!frame_active) begin
         state_q <= adcgc_pkg::ADCGC_IDLE;
      end else if (cmd_byte_valid) begin
         case (state_q)
            adcgc_pkg::ADCGC_IDLE: begin
               addr_q <= cmd_byte[`ADCGC_ADDR_HI:0];
               if (cmd_byte[`ADCGC_OP_HI:`ADCGC_OP_LO] == `ADCGC_OP_WRITE ||
                   cmd_byte[`ADCGC_OP_HI:`ADCGC_OP_LO] == `ADCGC_OP_READ) begin
                  state_q <= adcgc_pkg::ADCGC_COUNT;
               end
            end
            adcgc_pkg::ADCGC_COUNT: begin
               count_q <= cmd_byte[`ADCGC_ADDR_HI:0];
               state_q <= op_write_q ? adcgc_pkg::ADCGC_WRITE : adcgc_pkg::ADCGC_READ;
            end
            adcgc_pkg::ADCGC_WRITE, adcgc_pkg::ADCGC_READ: begin
               addr_q <= addr_q + 5'h01;
               count_q <= count_q - 5'h01;
               if (count_q == 5'h00) begin
                  state_q <= adcgc_pkg::ADCGC_IDLE;
               end
            end
            default: state_q <= adcgc_pkg::ADCGC_IDLE;
         endcase
      end
   end

   // remembers whether the first opcode byte asked for a write
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         op_write_q <= 1'b0;
      end else if (cmd_byte_valid && frame_active && state_q == adcgc_pkg::ADCGC_IDLE) begin
         op_write_q <= (cmd_byte[`ADCGC_OP_HI:`ADCGC_OP_LO] == `ADCGC_OP_WRITE);
      end
   end

   // register writes; fixed bits are held at their required values whatever the host sends
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         config_a_q <= `ADCGC_RST_CONFIG_A;
         config_b_q <= `ADCGC_RST_CONFIG_B;
         lead_ctrl_q <= `ADCGC_RST_LEAD_CTRL;
      end else if (wr_now) begin
         if (addr_q == `ADCGC_ADDR_CONFIG_A) begin
            config_a_q <= cmd_byte & `ADCGC_A_WRITE_MASK;
         end
         if (addr_q == `ADCGC_ADDR_CONFIG_B) begin
            config_b_q <= (cmd_byte & `ADCGC_B_WRITE_MASK) | `ADCGC_B_FORCED_ONES;
         end
         if (addr_q == `ADCGC_ADDR_LEAD_CTRL) begin
            lead_ctrl_q <= cmd_byte;
         end
      end
   end

   // read answer: one byte per byte the host clocks in during the data phase
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         rd_q <= 8'h00;
         rd_valid_q <= 1'b0;
      end else begin
         rd_valid_q <= cmd_byte_valid && frame_active && (state_q == adcgc_pkg::ADCGC_READ);
         if (cmd_byte_valid && frame_active && state_q == adcgc_pkg::ADCGC_READ) begin
            rd_q <= reg_view;
         end
      end
   end

   // pin synchronisers; a change counts once the second and third stages agree
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         start_sync_q <= 3'b000;
         osc_sync_q <= 3'b000;
         start_level_q <= 1'b0;
         osc_level_q <= 1'b0;
      end else begin
         start_sync_q <= {start_sync_q[1:0], start_pin};
         osc_sync_q <= {osc_sync_q[1:0], internal_osc_pin};
         if (start_sync_q[1] == start_sync_q[2]) begin
            start_level_q <= start_sync_q[2];
         end
         if (osc_sync_q[1] == osc_sync_q[2]) begin
            osc_level_q <= osc_sync_q[2];
         end
      end
   end

   assign start_rise = (start_sync_q[1] == start_sync_q[2]) && start_sync_q[2] && !start_level_q;

   // modulator clock enable from the system clock
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         mod_cnt_q <= 16'h0000;
      end else if (mod_tick) begin
         mod_cnt_q <= 16'h0000;
      end else begin
         mod_cnt_q <= mod_cnt_q + 16'h0001;
      end
   end
   assign mod_tick = (mod_cnt_q == 16'(MOD_DIV - 1));

   // ratio 1024 shifted down by the code; the forbidden code gives no conversions
   assign osr = `ADCGC_OSR_MAX >> config_a_q[`ADCGC_A_RATE_HI:0];

   // conversion pacing: single-shot arms on a start edge, continuous follows the start level
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         run_q <= 1'b0;
         dec_cnt_q <= 11'h000;
         ready_q <= 1'b0;
      end else begin
         ready_q <= 1'b0;
         if (config_a_q[`ADCGC_A_RATE_HI:0] == `ADCGC_RATE_FORBIDDEN || wr_now) begin
            run_q <= 1'b0; // new settings restart the decimator
            dec_cnt_q <= 11'h000;
         end else if (!run_q) begin
            dec_cnt_q <= 11'h000;
            if (config_a_q[`ADCGC_A_SINGLE_SHOT] ? start_rise : start_level_q) begin
               run_q <= 1'b1;
            end
         end else if (!config_a_q[`ADCGC_A_SINGLE_SHOT] && !start_level_q) begin
            run_q <= 1'b0;
         end else if (mod_tick) begin
            if (dec_cnt_q == osr - 11'h001) begin
               dec_cnt_q <= 11'h000;
               ready_q <= 1'b1;
               if (config_a_q[`ADCGC_A_SINGLE_SHOT]) begin
                  run_q <= 1'b0;
               end
            end else begin
               dec_cnt_q <= dec_cnt_q + 11'h001;
            end
         end
      end
   end

   // test signal: dc high when off square, toggling every half second when square
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         test_cnt_q <= 32'h00000000;
         test_phase_q <= 1'b0;
      end else if (!config_b_q[`ADCGC_B_TEST_ON] || !config_b_q[`ADCGC_B_TEST_SQUARE]) begin
         test_cnt_q <= 32'h00000000;
         test_phase_q <= 1'b0;
      end else if (test_cnt_q == 32'(TEST_HALF_CYCLES - 1)) begin
         test_cnt_q <= 32'h00000000;
         test_phase_q <= !test_phase_q;
      end else begin
         test_cnt_q <= test_cnt_q + 32'h00000001;
      end
   end

   // registered outputs
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         out_cfg_q <= 8'h00;
         clk_out_q <= 1'b0;
         test_level_q <= 1'b0;
      end else begin
         out_cfg_q <= config_b_q;
         clk_out_q <= config_b_q[`ADCGC_B_CLK_OUT] && osc_level_q;
         test_level_q <= config_b_q[`ADCGC_B_TEST_ON] &&
                         (!config_b_q[`ADCGC_B_TEST_SQUARE] || test_phase_q);
      end
   end

   assign lead_comparator_on = out_cfg_q[`ADCGC_B_LEAD_COMP];
   assign refbuffer_on = out_cfg_q[`ADCGC_B_REFBUF];
   assign high_reference_select = out_cfg_q[`ADCGC_B_HIGH_REF];
   assign test_signal_on = out_cfg_q[`ADCGC_B_TEST_ON];
   assign osc_clock_out_enable = clk_out_q;
   assign test_signal_level = test_level_q;
   assign lead_detect_control = lead_ctrl_q;
   assign single_shot_mode = config_a_q[`ADCGC_A_SINGLE_SHOT];
   assign rate_select = config_a_q[`ADCGC_A_RATE_HI:0];
   assign converting = run_q;
   assign data_ready = ready_q;
   assign read_byte = rd_q;
   assign read_byte_valid = rd_valid_q;
endmodule
`default_nettype wire

// ==== inc/adcgc_defines.svh ====
// offsets, field positions, reset values and timing figures of the global configuration block
`ifndef ADCGC_DEFINES_SVH
`define ADCGC_DEFINES_SVH
`define ADCGC_ADDR_CONFIG_A 5'h01
`define ADCGC_ADDR_CONFIG_B 5'h02
`define ADCGC_ADDR_LEAD_CTRL 5'h03
`define ADCGC_RST_CONFIG_A 8'h02
`define ADCGC_RST_CONFIG_B 8'h80
`define ADCGC_RST_LEAD_CTRL 8'h10
`define ADCGC_A_SINGLE_SHOT 7
`define ADCGC_A_RATE_HI 2
`define ADCGC_B_LEAD_COMP 6
`define ADCGC_B_REFBUF 5
`define ADCGC_B_HIGH_REF 4
`define ADCGC_B_CLK_OUT 3
`define ADCGC_B_TEST_ON 1
`define ADCGC_B_TEST_SQUARE 0
`define ADCGC_A_WRITE_MASK 8'h87
`define ADCGC_B_WRITE_MASK 8'h7B
`define ADCGC_B_FORCED_ONES 8'h80
`define ADCGC_OP_WRITE 3'h2
`define ADCGC_OP_READ 3'h1
`define ADCGC_OP_HI 7
`define ADCGC_OP_LO 5
`define ADCGC_ADDR_HI 4
`define ADCGC_RATE_FORBIDDEN 3'h7
`define ADCGC_OSR_MAX 11'h400
`define ADCGC_CLK_HZ 100000000
`define ADCGC_TEST_HZ 1
`define ADCGC_TEST_HALF_CYCLES (`ADCGC_CLK_HZ / (2 * `ADCGC_TEST_HZ))
`endif

// ==== inc/adcgc_pkg.sv ====
// types shared by the global configuration block
package adcgc_pkg;
   typedef enum logic [1:0] {
      ADCGC_IDLE = 2'b00,
      ADCGC_COUNT = 2'b01,
      ADCGC_WRITE = 2'b10,
      ADCGC_READ = 2'b11
   } adcgc_cmd_state_type;
endpackage

// ==== dv/adcgc_global_config_props.sv ====
// assertion checker for the global configuration block
`timescale 1ns/1ps
`default_nettype none
module adcgc_global_config_props (
   input wire logic clk,
   input wire logic rstn,
   input wire logic frame_active,
   input wire logic cmd_byte_valid,
   input wire logic internal_osc_pin,
   input wire logic read_byte_valid,
   input wire logic osc_clock_out_enable,
   input wire logic test_signal_on,
   input wire logic test_signal_level,
   input wire logic [7:0] lead_detect_control,
   input wire logic single_shot_mode,
   input wire logic [2:0] rate_select,
   input wire logic converting,
   input wire logic data_ready
);
   // one clock domain, so clock and reset are given once
   default clocking @(posedge clk); endclocking
   default disable iff (!rstn);
   // six low samples: two agreeing sync stages, the level flop and the output register
   sequence osc_low; !internal_osc_pin [*6]; endsequence
   sequence frame_idle; !frame_active [*2]; endsequence
   AST_RESET_DEFAULTS: assert property (
      $rose(rstn) |-> rate_select == 3'h2 && !single_shot_mode && lead_detect_control == 8'h10)
      else $error("register defaults wrong after reset");
   AST_OSC_GATED: assert property (osc_low |-> !osc_clock_out_enable)
      else $error("clock output enabled without internal oscillator");
   AST_TEST_OFF: assert property (!test_signal_on [*2] |-> !test_signal_level)
      else $error("test signal active while switched off");
   AST_READY_PULSE: assert property (data_ready |=> !data_ready)
      else $error("data ready longer than one cycle");
   AST_READY_FROM_CONV: assert property (data_ready |-> $past(converting))
      else $error("data ready without a running conversion");
   AST_FORBIDDEN_RATE: assert property ((rate_select == 3'h7) [*3] |-> !data_ready)
      else $error("conversion finished at the forbidden rate");
   AST_SINGLE_HALT: assert property (single_shot_mode && data_ready |-> !converting)
      else $error("single shot kept converting");
   AST_READ_IN_FRAME: assert property (frame_idle |-> !read_byte_valid)
      else $error("read data outside a frame");
   AST_READ_CAUSE: assert property (read_byte_valid |-> $past(cmd_byte_valid && frame_active))
      else $error("read data without a data phase byte");
endmodule
bind adcgc_global_config adcgc_global_config_props chk_u (.clk, .rstn, .frame_active, .cmd_byte_valid,
   .internal_osc_pin, .read_byte_valid, .osc_clock_out_enable, .test_signal_on, .test_signal_level,
   .lead_detect_control, .single_shot_mode, .rate_select, .converting, .data_ready);
`default_nettype wire

// ==== dv/adcgc_host_model.sv ====
// host controller model: frames register commands and collects read data
`timescale 1ns/1ps
`default_nettype none
module adcgc_host_model (
   input wire logic clk,
   output logic frame_active,
   output logic [7:0] cmd_byte,
   output logic cmd_byte_valid,
   input wire logic [7:0] read_byte,
   input wire logic read_byte_valid
);
   logic [7:0] rq[$];
   initial begin
      frame_active = 1'b0;
      cmd_byte = 8'hA5;
      cmd_byte_valid = 1'b0;
   end
   // opcode and address, count minus one, then data; slow leaves idle edges between bytes
   task automatic run(input logic [7:0] q[$], input bit slow);
      foreach (q[i]) begin
         if (slow && i > 0) begin
            @(posedge clk);
            cmd_byte_valid <= 1'b0;
         end
         @(posedge clk);
         frame_active <= 1'b1;
         cmd_byte <= q[i];
         cmd_byte_valid <= 1'b1;
      end
      @(posedge clk);
      cmd_byte_valid <= 1'b0;
      cmd_byte <= ~cmd_byte; // released line shows no stale byte
      @(posedge clk);
      frame_active <= 1'b0;
   endtask
   // read bytes are queued as they arrive
   always @(posedge clk) begin
      if (read_byte_valid === 1'b1) begin
         rq.push_back(read_byte);
      end
   end
endmodule
`default_nettype wire

// ==== dv/adcgc_global_config_test.sv ====
// self-checking bench for the global configuration block
`timescale 1ns/1ps
`default_nettype none
module adcgc_global_config_test;
   logic clk = 1'b0, rstn = 1'b0, start_pin = 1'b0, internal_osc_pin = 1'b0;
   logic frame_active, cmd_byte_valid, read_byte_valid, lead_comparator_on, refbuffer_on;
   logic high_reference_select, osc_clock_out_enable, test_signal_on, test_signal_level;
   logic single_shot_mode, converting, data_ready;
   logic [7:0] cmd_byte, read_byte, lead_detect_control, v;
   logic [2:0] rate_select;
   int seed = 32'h789C8F56;
   int fail_count = 0, num_checks = 0, cycles = 0, n;
   adcgc_host_model host_u (.clk, .frame_active, .cmd_byte, .cmd_byte_valid, .read_byte, .read_byte_valid);
   // a short test period keeps the square wave visible in simulation
   adcgc_global_config #(.TEST_HALF_CYCLES(8)) dut_u (.clk, .rstn, .frame_active, .cmd_byte,
      .cmd_byte_valid, .start_pin, .internal_osc_pin, .read_byte, .read_byte_valid, .lead_comparator_on,
      .refbuffer_on, .high_reference_select, .osc_clock_out_enable, .test_signal_on, .test_signal_level,
      .lead_detect_control, .single_shot_mode, .rate_select, .converting, .data_ready);
   always #5 clk = ~clk;
   // cut a hang short
   always @(posedge clk) begin
      cycles++;
      if (cycles == 30000) begin
         fail_count++;
         wrap_up();
      end
   end
   function automatic logic [7:0] outs_b(input logic [7:0] w, input logic osc);
      return {3'h0, w[6], w[5], w[4], w[3] & osc, w[1]};
   endfunction
   function automatic int conv_cycles(input logic [2:0] r);
      return (1024 >> r) * 4;
   endfunction
   task automatic chk(input string nm, input logic [7:0] got, input logic [7:0] exp);
      num_checks++;
      if (got !== exp) begin
         fail_count++;
         $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task automatic wr(input logic [4:0] a, input logic [7:0] d);
      host_u.run('{{3'h2, a}, 8'h00, d}, 1'b0);
      repeat (2) @(posedge clk);
   endtask
   task automatic rd(input logic [4:0] a, input int cnt, input bit slow);
      logic [7:0] q[$];
      q = '{{3'h1, a}, 8'(cnt - 1)};
      repeat (cnt) q.push_back(8'hFF);
      host_u.rq.delete();
      host_u.run(q, slow);
      repeat (3) @(posedge clk);
   endtask
   task automatic count_ready(input int cyc, output int cnt);
      cnt = 0;
      repeat (cyc) begin
         @(posedge clk);
         cnt += (data_ready === 1'b1);
      end
   endtask
   task automatic wrap_up();
      $display("checks %0d mismatches %0d", num_checks, fail_count);
      if (fail_count == 0 && num_checks > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   initial begin
      repeat (6) @(posedge clk);
      rstn <= 1'b1;
      rd(5'h01, 3, 1'b0);
      chk("read count", 8'(host_u.rq.size()), 8'h03);
      chk("lead ctrl reset", host_u.rq[2], 8'h10);
      chk("lead ctrl out", lead_detect_control, 8'h10);
      chk("cfg a reset", host_u.rq[0], 8'h02);
      chk("cfg b reset", host_u.rq[1], 8'h80);
      chk("outs reset", {3'h0, lead_comparator_on, refbuffer_on, high_reference_select,
         osc_clock_out_enable, test_signal_on}, outs_b(8'h80, internal_osc_pin));
      chk("test reset", 8'(test_signal_level), 8'h00);
      // random config b values, test modes cycled; host keeps bit 7 set and bit 2 clear
      for (int i = 0; i < 12; i++) begin
         v = (8'($random(seed)) & 8'h78) | 8'h80 | 8'(i & 3);
         internal_osc_pin <= v[2] ^ v[6];
         wr(5'h02, v);
         chk("cfg b outs", {3'h0, lead_comparator_on, refbuffer_on, high_reference_select,
            osc_clock_out_enable, test_signal_on}, outs_b(v, internal_osc_pin));
         // square wave restarts low, so one half period later it must be high
         chk("test level", 8'(test_signal_level), 8'(v[1] & !v[0]));
         repeat (8) @(posedge clk);
         chk("test level later", 8'(test_signal_level), 8'(v[1]));
         rd(5'h02, 1, i[0]);
         chk("cfg b read", host_u.rq[0], v);
      end
      for (int r = 0; r < 7; r++) begin
         v = {r[0], 4'h0, 3'(r)};
         wr(5'h01, v);
         chk("cfg a outs", {single_shot_mode, 4'h0, rate_select}, v);
      end
      // reset in mid-run: registers and outputs fall back to their defaults
      rstn <= 1'b0;
      repeat (2) @(posedge clk);
      rstn <= 1'b1;
      rd(5'h01, 2, 1'b1);
      chk("cfg a again", host_u.rq[0], 8'h02);
      chk("cfg b again", host_u.rq[1], 8'h80);
      chk("outs again", {2'h0, test_signal_level, lead_comparator_on, refbuffer_on, high_reference_select,
         osc_clock_out_enable, test_signal_on}, 8'h00);
      rd(5'h1F, 1, 1'b0);
      chk("unmapped", host_u.rq[0], 8'h00);
      // continuous mode: about eight conversions per eight periods
      start_pin <= 1'b1;
      for (int r = 3; r < 7; r++) begin
         wr(5'h01, 8'(r));
         count_ready(8 * conv_cycles(3'(r)), n);
         chk("rate count", 8'(n >= 7 && n <= 9), 8'h01);
      end
      wr(5'h01, 8'h07);
      count_ready(300, n);
      chk("forbidden", 8'(n), 8'h00);
      start_pin <= 1'b0;
      wr(5'h01, 8'h86);
      repeat (10) @(posedge clk);
      start_pin <= 1'b1;
      count_ready(4 * conv_cycles(3'h6), n);
      chk("single shot", {7'h0, converting} | 8'(n << 1), 8'h02);
      wrap_up();
   end
endmodule
`default_nettype wire
